// ==== rtl/counter_pkg.sv ====
// Shared constants and carrier types for the counter channel.
// Assumes one 10 MHz system clock; all link signals sampled as synchronous.
package counter_pkg;
    localparam int CNT_W          = 32;
    localparam int TERM_N         = 16;
    localparam int TERM_SEL_W     = 5;
    // Terminal selects 0..15 are terminals, 16 is the differential star output
    localparam logic [4:0] SEL_STAR_OUT       = 5'h10;
    localparam logic [4:0] SEL_NONE           = 5'h1f;
    localparam logic [4:0] DEF_SRC_TERM       = 5'h08;
    localparam logic [4:0] DEF_GATE_TERM      = 5'h09;
    localparam logic [4:0] DEF_AUX_TERM       = 5'h0a;
    localparam logic [4:0] DEF_OUT_TERM       = 5'h0c;
    localparam logic [4:0] DEF_FREQ_TERM      = 5'h0e;
    // Source kinds
    localparam logic [1:0] SRC_EXTERNAL       = 2'h0;
    localparam logic [1:0] SRC_FAST_INTERNAL  = 2'h1;
    localparam logic [1:0] SRC_MEDIUM_INTERNAL = 2'h2;
    localparam logic [1:0] SRC_SLOW_INTERNAL  = 2'h3;
    // Prescale settings
    localparam logic [1:0] PRESCALE_OFF       = 2'h0;
    localparam logic [1:0] PRESCALE_DIV2      = 2'h1;
    localparam logic [1:0] PRESCALE_DIV8      = 2'h2;
    localparam logic [2:0] WRAP_DIV2          = 3'h1;
    localparam logic [2:0] WRAP_DIV8          = 3'h7;
    // Gate usage
    localparam logic [1:0] GATE_NONE          = 2'h0;
    localparam logic [1:0] GATE_START         = 2'h1;
    localparam logic [1:0] GATE_PAUSE         = 2'h2;
    // Fast pipeline depth: count on third source edge
    localparam int FAST_SYNC_STAGES           = 3;
    localparam logic [CNT_W-1:0] COUNT_RESET  = 32'h0000_0000;

    typedef struct packed {
        logic [1:0]       source_kind;
        logic             source_fast;   // external source above 25 MHz
        logic [1:0]       prescale;
        logic [1:0]       gate_use;
        logic             pause_level;   // gate level that pauses
        logic             generate_mode; // 1 output task, 0 edge counting
        logic             continuous;
        logic             retrigger;
        logic             toggle_out;
        logic             out_invert;
        logic             dir_from_b;
        logic             count_down;
        logic             hardware_enable_input_en;
        logic             cascade_gate;  // gate from other counter
        logic [CNT_W-1:0] pulse_count;
        logic [CNT_W-1:0] period;
    } counter_cfg_t;

    typedef struct packed {
        logic [TERM_SEL_W-1:0] source_sel;
        logic [TERM_SEL_W-1:0] gate_sel;
        logic [TERM_SEL_W-1:0] aux_sel;
        logic [TERM_SEL_W-1:0] out_sel;
        logic [TERM_SEL_W-1:0] freq_sel;
    } route_cfg_t;
endpackage

// ==== rtl/input_sync.sv ====
// Synchroniser of counter inputs onto count-source ticks.
// Assumes source tick and delayed tick are one-cycle enables of sys_clk_i.
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH  = 4,
    parameter int STAGES = 3
) (
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             fast_mode_i,
    input  wire logic             tick_i,
    input  wire logic             delayed_tick_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_q [STAGES-1];
    logic [WIDTH-1:0] slow_q;

    if (STAGES < 2) $error("input_sync needs two stages or more");

    // [RULE21] Pipelined fast sync
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < STAGES-1; i++) stage_q[i] <= '0;
        end else if (tick_i) begin
            stage_q[0] <= async_i;
            for (int i = 1; i < STAGES-1; i++) stage_q[i] <= stage_q[i-1];
        end
    end

    // [RULE22] Delayed-copy sync
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            slow_q <= '0;
        end else if (delayed_tick_i) begin
            slow_q <= async_i;
        end
    end

    // [RULE20] Select sync path
    assign sync_o = fast_mode_i ? stage_q[STAGES-2] : slow_q;
endmodule

// ==== rtl/counter_channel.sv ====
// Counter/timer channel: arming, triggers, generation, prescale, routing.
// Assumes terminals and source edges are synchronous to sys_clk_i.
//
// Function
// [RULE1] Frequency output routable to terminals 0..15 or star output; terminals idle undriven.
// [RULE2] Frequency output selectable as digital in/out sample clock.
// [RULE3] Defaults: source 8, gate 9, first-edge 10, output on terminal 12.
// [RULE4] All default terminal assignments can be overridden by configuration.
// [RULE5] Nothing counts or generates before the counter is armed.
// [RULE6] Arm by software command or by hardware enable input.
// [RULE7] Outputs combine arm with start/pause; inputs start at arm.
// [RULE8] Start trigger begins generation; continuous runs until software stops.
// [RULE9] Finite emits exact pulse count; retriggerable restarts on later triggers. Code ends one pulse short if paused at the last terminal count.
// [RULE10] Start trigger arrives on the gating input.
// [RULE11] Pause level holds the count in edge counting; level selectable.
// [RULE12] Pause level suspends continuous pulse output; polarity selectable.
// [RULE13] Pause trigger arrives on the gating input.
// [RULE14] Output and terminal count route to other counters' gates for cascading.
// [RULE15] Prescaler offers divide-by-8, divide-by-2, or bypass.
// [RULE16] Prescaler wraps after eight or two edges; main counter counts wraps.
// [RULE17] Prescaler count is not readable by software.
// [RULE18] Prescaling only with external source, never internal timebases.
// [RULE19] Main counter is 32 bits, steps on selected source edge.
// [RULE20] Gate and other inputs are synchronised to the source; hardware enable arming uses the raw input instead.
// [RULE21] Fast sources: sync on rising edges, count on third edge, pipelined.
// [RULE22] Slow sources: sync on delayed source copy, count next edge.
// [RULE23] Output pulses or toggles on terminal count, with selectable polarity.
// [RULE24] Direction input may select up or down counting.
// [RULE25] Source edge increments or decrements per application.
// [RULE26] Triggers before arming are ignored.
// [RULE27] Sync mode latched at arming, fixed while task runs.
`timescale 1ns/1ps
module counter_channel #(
    parameter int CNT_WIDTH = counter_pkg::CNT_W,
    parameter int TERMS     = counter_pkg::TERM_N
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        sys_rst_i,
    input  wire counter_pkg::counter_cfg_t   cfg_i,
    input  wire counter_pkg::route_cfg_t     route_i,
    input  wire logic                        route_default_i,
    input  wire logic                        sw_arm_i,
    input  wire logic                        sw_stop_i,
    input  wire logic                        hardware_enable_input_i,
    input  wire logic                        fast_internal_timebase_i,
    input  wire logic                        medium_internal_timebase_i,
    input  wire logic                        slow_internal_timebase_i,
    input  wire logic [TERMS-1:0]            programmable_function_terminal_i,
    input  wire logic                        cascade_in_i,
    input  wire logic                        frequency_generator_output_i,
    input  wire logic                        freq_to_di_clk_i,
    input  wire logic                        freq_to_do_clk_i,
    output logic      [TERMS-1:0]            programmable_function_terminal_o,
    output logic      [TERMS-1:0]            programmable_function_terminal_oe_o,
    output logic                             differential_star_trigger_output_o,
    output logic                             di_sample_clock_o,
    output logic                             do_sample_clock_o,
    output logic                             counter_zero_output_o,
    output logic                             terminal_count_o,
    output logic                             armed_o,
    output logic                             running_o,
    output logic      [CNT_WIDTH-1:0]        count_o
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_DONE  = 4'b1000
    } state_t;

    if (CNT_WIDTH != 32) $error("counter width must be 32");
    if (TERMS > 16 || TERMS < 13) $error("terminal count must be 13..16");

    // Picks one terminal by select code; codes past the terminals read low
    function automatic logic pick_term(input logic [TERMS-1:0] t, input logic [4:0] sel);
        pick_term = (sel < 5'(TERMS)) ? t[sel[3:0]] : 1'b0;
    endfunction

    state_t                 state_q;
    logic [CNT_WIDTH-1:0]   count_q;
    logic [CNT_WIDTH-1:0]   pulses_q;
    logic [2:0]             pre_q;
    logic                   src_q;
    logic                   src_dly_q;
    logic                   fast_mode_q;
    logic                   out_q;
    logic                   tc_q;
    logic                   gate_prev_q;
    logic                   hardware_enable_input_prev_q;
    logic                   tick;
    logic                   dly_tick;
    logic                   src_raw;
    logic                   count_tick;
    logic                   pre_allowed;
    logic [2:0]             wrap;
    counter_pkg::route_cfg_t rt;
    logic [3:0]             async_in;
    logic [3:0]             synced;
    logic                   gate_s;
    logic                   aux_s;
    logic                   dir_b_s;
    logic                   arm_req;
    logic                   start_evt;
    logic                   paused;
    logic                   count_down;
    logic                   at_tc;
    logic                   out_level;

    // [RULE3] Default terminals
    // [RULE4] Configured override
    always_comb begin
        if (route_default_i) begin
            rt.source_sel = counter_pkg::DEF_SRC_TERM;
            rt.gate_sel   = counter_pkg::DEF_GATE_TERM;
            rt.aux_sel    = counter_pkg::DEF_AUX_TERM;
            rt.out_sel    = counter_pkg::DEF_OUT_TERM;
            rt.freq_sel   = counter_pkg::DEF_FREQ_TERM;
        end else begin
            rt = route_i;
        end
    end

    always_comb begin
        case (cfg_i.source_kind)
            counter_pkg::SRC_FAST_INTERNAL:   src_raw = fast_internal_timebase_i;
            counter_pkg::SRC_MEDIUM_INTERNAL: src_raw = medium_internal_timebase_i;
            counter_pkg::SRC_SLOW_INTERNAL:   src_raw = slow_internal_timebase_i;
            default: src_raw = pick_term(programmable_function_terminal_i, rt.source_sel);
        endcase
    end

    // Source edge detector, plus a one-cycle late copy for the slow path
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            src_q     <= 1'b0;
            src_dly_q <= 1'b0;
        end else begin
            src_q     <= src_raw;
            src_dly_q <= tick;
        end
    end
    // [RULE19] Selected source edge
    assign tick     = src_raw & ~src_q;
    // [RULE22] Delayed source copy
    assign dly_tick = src_dly_q;

    // [RULE27] Mode fixed at arm
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            fast_mode_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            fast_mode_q <= (cfg_i.source_kind == counter_pkg::SRC_FAST_INTERNAL) |
                           ((cfg_i.source_kind == counter_pkg::SRC_EXTERNAL) & cfg_i.source_fast);
        end
    end

    // [RULE14] Cascade into gate
    assign async_in = {hardware_enable_input_i,
                       pick_term(programmable_function_terminal_i, rt.aux_sel),
                       pick_term(programmable_function_terminal_i, rt.aux_sel),
                       cfg_i.cascade_gate ? cascade_in_i
                           : pick_term(programmable_function_terminal_i, rt.gate_sel)};

    input_sync #(
        .WIDTH  (4),
        .STAGES (counter_pkg::FAST_SYNC_STAGES)
    ) u_sync (
        .sys_clk_i      (sys_clk_i),
        .sys_rst_i      (sys_rst_i),
        .fast_mode_i    (fast_mode_q),
        .tick_i         (tick),
        .delayed_tick_i (dly_tick),
        .async_i        (async_in),
        .sync_o         (synced)
    );
    assign gate_s  = synced[0];
    assign dir_b_s = synced[1];
    assign aux_s   = synced[2];

    // [RULE18] External source only
    assign pre_allowed = (cfg_i.source_kind == counter_pkg::SRC_EXTERNAL) &
                         (cfg_i.prescale != counter_pkg::PRESCALE_OFF);
    assign wrap = (cfg_i.prescale == counter_pkg::PRESCALE_DIV8) ? counter_pkg::WRAP_DIV8
                                                                 : counter_pkg::WRAP_DIV2;
    // [RULE17] Prescaler kept internal
    // [RULE16] Wrap then count
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !pre_allowed || state_q == ST_IDLE) begin
            pre_q <= 3'h0;
        end else if (tick) begin
            pre_q <= (pre_q == wrap) ? 3'h0 : pre_q + 3'h1;
        end
    end
    // [RULE15] Divide or bypass
    assign count_tick = pre_allowed ? (tick && pre_q == wrap) : (fast_mode_q ? tick : dly_tick);

    // [RULE6] Software or hardware arm
    assign arm_req = sw_arm_i | (cfg_i.hardware_enable_input_en & hardware_enable_input_i & ~hardware_enable_input_prev_q);
    // [RULE10] Gate is start
    // [RULE26] Ignored unless armed
    assign start_evt = (cfg_i.gate_use == counter_pkg::GATE_START) & gate_s & ~gate_prev_q;
    // [RULE11] Pause level hold
    // [RULE13] Gate is pause
    assign paused = (cfg_i.gate_use == counter_pkg::GATE_PAUSE) & (gate_s == cfg_i.pause_level);
    // [RULE24] Direction input
    assign count_down = cfg_i.dir_from_b ? ~dir_b_s : cfg_i.count_down;
    assign at_tc = cfg_i.generate_mode ? (count_q == '0)
                                       : (count_down ? count_q == '0 : &count_q);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gate_prev_q   <= 1'b0;
            hardware_enable_input_prev_q <= 1'b0;
        end else begin
            gate_prev_q   <= gate_s;
            hardware_enable_input_prev_q <= hardware_enable_input_i;
        end
    end

    // [RULE5] Arm before run
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || sw_stop_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (arm_req) begin
                        // [RULE7] Arm starts inputs
                        state_q <= (!cfg_i.generate_mode ||
                                    cfg_i.gate_use != counter_pkg::GATE_START) ? ST_RUN
                                                                               : ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    // [RULE8] Start begins output
                    if (start_evt) state_q <= ST_RUN;
                end
                ST_RUN: begin
                    // [RULE9] Finite stop
                    if (cfg_i.generate_mode && !cfg_i.continuous && count_tick && at_tc &&
                        pulses_q == 32'h0000_0001) state_q <= ST_DONE;
                end
                ST_DONE: begin
                    // [RULE9] Retrigger restart
                    if (cfg_i.retrigger && start_evt) state_q <= ST_RUN;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // [RULE25] Step up or down
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || state_q == ST_IDLE) begin
            count_q <= cfg_i.generate_mode ? cfg_i.period : counter_pkg::COUNT_RESET;
        end else if ((state_q == ST_ARMED || state_q == ST_DONE) && start_evt) begin
            count_q <= cfg_i.period;
        end else if (state_q == ST_RUN && count_tick && !paused) begin
            if (cfg_i.generate_mode) begin
                // [RULE12] Pause suspends pulses
                count_q <= at_tc ? cfg_i.period : count_q - 32'h0000_0001;
            end else begin
                count_q <= count_down ? count_q - 32'h0000_0001 : count_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || state_q == ST_IDLE) begin
            pulses_q <= cfg_i.pulse_count;
        end else if ((state_q == ST_ARMED || state_q == ST_DONE) && start_evt) begin
            pulses_q <= cfg_i.pulse_count;
        end else if (state_q == ST_RUN && count_tick && !paused && at_tc &&
                     cfg_i.generate_mode) begin
            pulses_q <= pulses_q - 32'h0000_0001;
        end
    end

    // [RULE23] Pulse or toggle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || state_q == ST_IDLE) begin
            tc_q  <= 1'b0;
            out_q <= 1'b0;
        end else begin
            tc_q <= state_q == ST_RUN && count_tick && !paused && at_tc;
            if (state_q == ST_RUN && count_tick && !paused && at_tc) begin
                out_q <= cfg_i.toggle_out ? ~out_q : 1'b1;
            end else if (!cfg_i.toggle_out) begin
                out_q <= 1'b0;
            end
        end
    end
    assign out_level = out_q ^ cfg_i.out_invert;

    // [RULE1] Terminal drive, idle undriven
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            programmable_function_terminal_o    <= '0;
            programmable_function_terminal_oe_o <= '0;
            differential_star_trigger_output_o  <= 1'b0;
        end else begin
            for (int i = 0; i < TERMS; i++) begin
                programmable_function_terminal_oe_o[i] <= (rt.out_sel == 5'(i)) ||
                                                          (rt.freq_sel == 5'(i));
                programmable_function_terminal_o[i] <= (rt.out_sel == 5'(i)) ? out_level
                    : ((rt.freq_sel == 5'(i)) & frequency_generator_output_i);
            end
            differential_star_trigger_output_o <= (rt.freq_sel == counter_pkg::SEL_STAR_OUT) &
                                                  frequency_generator_output_i;
        end
    end

    // [RULE2] Frequency as sample clock
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            di_sample_clock_o <= 1'b0;
            do_sample_clock_o <= 1'b0;
        end else begin
            di_sample_clock_o <= freq_to_di_clk_i & frequency_generator_output_i;
            do_sample_clock_o <= freq_to_do_clk_i & frequency_generator_output_i;
        end
    end

    // [RULE14] Output and terminal count exported
    assign counter_zero_output_o = out_level;
    assign terminal_count_o      = tc_q;
    assign armed_o               = state_q != ST_IDLE;
    assign running_o             = state_q == ST_RUN;
    assign count_o               = count_q;
endmodule

// ==== verification/counter_channel_checker.sv ====
// Port-level checker for counter_channel, attached by bind.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module counter_channel_checker #(
    parameter int TERMS = 16
) (
    input wire logic                     sys_clk_i,
    input wire logic                     sys_rst_i,
    input wire counter_pkg::counter_cfg_t cfg_i,
    input wire counter_pkg::route_cfg_t  route_i,
    input wire logic                     route_default_i,
    input wire logic                     sw_arm_i,
    input wire logic                     sw_stop_i,
    input wire logic                     hardware_enable_input_i,
    input wire logic                     frequency_generator_output_i,
    input wire logic [TERMS-1:0]         programmable_function_terminal_o,
    input wire logic [TERMS-1:0]         programmable_function_terminal_oe_o,
    input wire logic                     differential_star_trigger_output_o,
    input wire logic                     terminal_count_o,
    input wire logic                     armed_o,
    input wire logic                     running_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_star_sel;
        !route_default_i && route_i.freq_sel == counter_pkg::SEL_STAR_OUT;
    endsequence
    // A pending terminal count may land just after arming drops
    sequence s_idle3;
        !armed_o [*3];
    endsequence
    a_reset_undriven: assert property ($fell(sys_rst_i) |->
        programmable_function_terminal_oe_o == '0) else $error("terminal driven after reset");
    a_sw_arm: assert property (sw_arm_i && !armed_o && !sw_stop_i |=> armed_o)
        else $error("software arm not taken");
    a_hardware_enable_input: assert property (cfg_i.hardware_enable_input_en && $rose(hardware_enable_input_i) &&
        !armed_o && !sw_stop_i |=> armed_o) else $error("hardware arm not taken");
    a_run_needs_arm: assert property (running_o |-> armed_o)
        else $error("running while unarmed");
    a_stop_halts: assert property (sw_stop_i |=> !running_o && !armed_o)
        else $error("stop did not halt");
    a_tc_single: assert property (terminal_count_o |=> !terminal_count_o)
        else $error("terminal count wider than one cycle");
    a_tc_idle: assert property (s_idle3 |-> !terminal_count_o)
        else $error("terminal count while unarmed");
    a_star_route: assert property (s_star_sel ##1 s_star_sel |->
        differential_star_trigger_output_o == $past(frequency_generator_output_i))
        else $error("star output not following frequency output");
    a_default_freq: assert property (route_default_i [*2] |->
        programmable_function_terminal_oe_o[14] &&
        programmable_function_terminal_o[14] == $past(frequency_generator_output_i))
        else $error("default frequency terminal wrong");
endmodule
bind counter_channel counter_channel_checker #(.TERMS(TERMS)) counter_channel_checker_inst (.*);

// ==== verification/terminal_partner.sv ====
// Far-side model: external source, gate and direction levels on terminals.
// Assumes one system clock; the source stands low while idle.
`timescale 1ns/1ps
module terminal_partner (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        gate_i,
    input  wire logic        dir_i,
    output logic      [15:0] pfi_o,
    output int               edges_o
);
    logic [1:0]  div_q = 2'h0;
    logic        src_q = 1'b0;
    logic [15:0] junk_q = 16'h5a5a;
    assign pfi_o = {junk_q[15:11], dir_i, gate_i, src_q, junk_q[7:0]};
    initial edges_o = 0;
    // Unused terminals flip every cycle so stale values never look valid
    always @(posedge clk_i) begin
        div_q  <= div_q + 2'h1;
        junk_q <= ~junk_q;
        if (!go_i)
            src_q <= 1'b0;
        else if (div_q == 2'h3) begin
            src_q <= ~src_q;
            if (!src_q)
                edges_o <= edges_o + 1;
        end
    end
endmodule

// ==== verification/counter_channel_tb.sv ====
// Self-checking bench for counter_channel with a terminal-side partner.
// Assumes counter_pkg, the partner and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
module counter_channel_tb;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, sw_arm = 1'b0, sw_stop = 1'b0, hwen = 1'b0;
    logic go = 1'b0, gate = 1'b0, dir = 1'b0, dflt = 1'b1, fq = 1'b0, fdi = 1'b0;
    logic tc, armed, run, zo;
    logic [15:0] programmable_function_terminal;
    logic [31:0] cnt;
    logic [31:0] seed = 32'h197f;
    counter_pkg::counter_cfg_t cfg = '0, nc = '0;
    counter_pkg::route_cfg_t   rt = '1;
    int err_total = 0, n_tests = 0, edges, tcs = 0, n, dv;
    terminal_partner terminal_partner_inst (.clk_i(sys_clk_i), .go_i(go), .gate_i(gate),
        .dir_i(dir), .pfi_o(programmable_function_terminal), .edges_o(edges));
    counter_channel counter_channel_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg), .route_i(rt),
        .route_default_i(dflt), .sw_arm_i(sw_arm), .sw_stop_i(sw_stop),
        .hardware_enable_input_i(hwen), .fast_internal_timebase_i(1'b0),
        .medium_internal_timebase_i(programmable_function_terminal[8]), .slow_internal_timebase_i(1'b0),
        .programmable_function_terminal_i(programmable_function_terminal), .cascade_in_i(1'b0),
        .frequency_generator_output_i(fq), .freq_to_di_clk_i(fdi), .freq_to_do_clk_i(fdi),
        .programmable_function_terminal_o(), .programmable_function_terminal_oe_o(),
        .differential_star_trigger_output_o(), .di_sample_clock_o(), .do_sample_clock_o(),
        .counter_zero_output_o(zo), .terminal_count_o(tc), .armed_o(armed), .running_o(run),
        .count_o(cnt));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        seed <= xs(seed);
        fq   <= seed[0];
        fdi  <= seed[3];
        if (tc === 1'b1)
            tcs++;
        if (!sys_rst_i)
            `CHK(zo, tc)
    end
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask
    task automatic finish_test(input bit hung);
        if (hung)
            err_total++;
        $display("counts: %0d compared, %0d mismatched", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset;
        cfg <= nc;
        sys_rst_i <= 1'b1;
        tick(10);
        sys_rst_i <= 1'b0;
        tick(2);
        tcs = 0;
    endtask
    task automatic arm_it;
        sw_arm <= 1'b1;
        tick(1);
        sw_arm <= 1'b0;
        tick(2);
    endtask
    // Runs the partner's source for k rising edges, bounded
    task automatic pulses(input int k);
        int e0;
        e0 = edges;
        go <= 1'b1;
        for (int i = 0; i < 40 * k + 40 && edges < e0 + k; i++)
            tick(1);
        go <= 1'b0;
        if (edges < e0 + k)
            finish_test(1);
        tick(12);
    endtask
    initial begin
        rt = {5'h08, 5'h09, 5'h0a, counter_pkg::SEL_NONE, counter_pkg::SEL_STAR_OUT};
        do_reset;
        pulses(4);
        `CHK(cnt, 32'h0)
        `CHK(run, 1'b0)
        $display("test unarmed done");
        for (int k = 0; k < 5; k++) begin
            n = 8 * (int'(seed[2:0]) + 1);
            dv = k == 1 ? 2 : k == 2 ? 8 : 1;
            nc.prescale = k % 4 == 0 ? counter_pkg::PRESCALE_OFF :
                k == 1 ? counter_pkg::PRESCALE_DIV2 : counter_pkg::PRESCALE_DIV8;
            nc.source_kind = k == 3 ? counter_pkg::SRC_MEDIUM_INTERNAL : counter_pkg::SRC_EXTERNAL;
            nc.source_fast = k == 4;
            do_reset;
            arm_it;
            `CHK(run, 1'b1)
            pulses(n);
            `CHK(cnt, 32'(n / dv))
            $display("test prescale %0d done", k);
        end
        nc = '0;
        nc.dir_from_b = 1'b1;
        do_reset;
        arm_it;
        pulses(5);
        `CHK(cnt, 32'hffff_fffb)
        $display("test down count done");
        dflt <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            nc = '0;
            nc.gate_use = counter_pkg::GATE_PAUSE;
            nc.pause_level = p[0];
            gate <= p[0];
            do_reset;
            arm_it;
            pulses(6);
            `CHK(cnt <= 32'h1, 1'b1)
            gate <= ~p[0];
            pulses(6);
            `CHK(cnt >= 32'h5 && cnt <= 32'h7, 1'b1)
            $display("test pause %0d done", p);
        end
        nc = '0;
        nc.generate_mode = 1'b1;
        nc.gate_use = counter_pkg::GATE_START;
        nc.retrigger = 1'b1;
        nc.period = 32'h3;
        nc.pulse_count = 32'h3;
        do_reset;
        go <= 1'b1;
        gate <= 1'b1;
        tick(40);
        gate <= 1'b0;
        arm_it;
        tick(100);
        `CHK(tcs, 0)
        `CHK(run, 1'b0)
        for (int r = 1; r < 3; r++) begin
            gate <= 1'b1;
            tick(40);
            gate <= 1'b0;
            tick(400);
            `CHK(tcs, 3 * r)
            `CHK(run, 1'b0)
        end
        $display("test retrigger done");
        nc = '0;
        nc.generate_mode = 1'b1;
        nc.continuous = 1'b1;
        nc.hardware_enable_input_en = 1'b1;
        nc.period = 32'h2;
        do_reset;
        hwen <= 1'b1;
        tick(3);
        `CHK(armed, 1'b1)
        tick(300);
        `CHK(tcs > 5, 1'b1)
        sw_stop <= 1'b1;
        tick(1);
        sw_stop <= 1'b0;
        tick(2);
        `CHK(run, 1'b0)
        n = tcs;
        tick(100);
        `CHK(tcs, n)
        $display("test continuous done");
        finish_test(0);
    end
endmodule
